// file: hdl/gpio_pkg.sv
// Constants, register map and mode codes for the GPIO port block.
// Assumes a 32-bit Avalon-MM slave with byte addressing.
package gpio_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int PORTS    = 3;
  localparam int PINS     = 8;
  localparam int NPIN     = 24;
  localparam int ADDR_W   = 8;
  localparam int REG_PIN  = 7;

  // ----------------------------------------------------------------
  // Pin mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_ANALOG   = 4'h0;
  localparam logic [3:0] MODE_IN_FLOAT = 4'h4;
  localparam logic [3:0] MODE_IN_PULL  = 4'h8;
  localparam logic [3:0] MODE_OUT_PP   = 4'h1;
  localparam logic [3:0] MODE_OUT_OD   = 4'h5;
  localparam logic [3:0] MODE_ALT_PP   = 4'h9;
  localparam logic [3:0] MODE_ALT_OD   = 4'hD;

  // ----------------------------------------------------------------
  // Register map: ADDRESS[6:5] selects port, ADDRESS[4:2] the register
  // ----------------------------------------------------------------
  localparam logic [1:0] BLK_MISC  = 2'h3;
  localparam logic [2:0] REG_CFGL  = 3'h0;
  localparam logic [2:0] REG_CFGH  = 3'h1;
  localparam logic [2:0] REG_IN    = 3'h2;
  localparam logic [2:0] REG_OUT   = 3'h3;
  localparam logic [2:0] REG_SET   = 3'h4;
  localparam logic [2:0] REG_CLR   = 3'h5;
  localparam logic [2:0] REG_WAKE  = 3'h6;
  localparam logic [2:0] REG_CTRL  = 3'h0;
  localparam logic [2:0] REG_STAT  = 3'h1;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EXTREG = 0;
  localparam int CTRL_V18    = 1;
  localparam int CTRL_V125   = 2;
  localparam logic [15:0] CFG_RST  = 16'h4444;
  localparam logic [7:0]  OUT_RST  = 8'h00;
  localparam logic [7:0]  WAKE_RST = 8'h00;
  localparam logic [2:0]  CTRL_RST = 3'h7;

  // Byte-lane merge of an 8-bit register held in lane 0
  function automatic logic [7:0] merge8(logic [7:0] old, logic [31:0] wd,
                                        logic [3:0] be);
    merge8 = be[0] ? wd[7:0] : old;
  endfunction : merge8

  // Byte-lane merge of a 16-bit register held in lanes 1:0
  function automatic logic [15:0] merge16(logic [15:0] old, logic [31:0] wd,
                                          logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

endpackage : gpio_pkg

// file: hdl/gpio_pin_cell.sv
// One pin: mode decode, output source select, pull and analog control.
// Purely combinational; the port block registers mode, out_bit, the overrides and in_stage, but not pad or peripheral signals.
`timescale 1ns/1ns
module gpio_pin_cell (
  input  wire logic [3:0] mode,
  input  wire logic       out_bit,
  input  wire logic       alt_bit,
  input  wire logic       alt_ok,
  input  wire logic       pad_in,
  input  wire logic       force_od,
  input  wire logic       force_low,
  output logic            pad_out,
  output logic            pad_oe_n,
  output logic            pull_en,
  output logic            pull_up,
  output logic            analog,
  output logic            in_stage
);

  logic alt_data;

  always_comb begin
    // No peripheral behind the pin drives a constant zero
    alt_data = alt_ok ? alt_bit : 1'b0;
    pad_out  = 1'b0;
    pad_oe_n = 1'b1;
    pull_en  = 1'b0;
    pull_up  = 1'b0;
    analog   = 1'b0;
    case (mode)
      gpio_pkg::MODE_ANALOG: begin
        analog = 1'b1;
      end
      gpio_pkg::MODE_IN_PULL: begin
        pull_en = 1'b1;
        pull_up = out_bit;
      end
      gpio_pkg::MODE_OUT_PP: begin
        pad_out  = out_bit;
        pad_oe_n = 1'b0;
      end
      gpio_pkg::MODE_OUT_OD: begin
        pad_oe_n = out_bit;
      end
      gpio_pkg::MODE_ALT_PP: begin
        pad_out  = alt_data;
        pad_oe_n = 1'b0;
      end
      gpio_pkg::MODE_ALT_OD: begin
        pad_oe_n = alt_data;
      end
      default: begin
        // Floating input and unlisted codes leave the driver off
        pad_oe_n = 1'b1;
      end
    endcase
    // Regulator-enable override beats the configured mode
    if (force_od) begin
      pad_out  = 1'b0;
      pad_oe_n = ~force_low;
      pull_en  = 1'b0;
      pull_up  = 1'b0;
      analog   = 1'b0;
    end
    // Analog mode feeds a high level instead of the pad
    in_stage = analog ? 1'b1 : pad_in;
  end

endmodule : gpio_pin_cell

// file: hdl/gpio_port_control.sv
// GPIO port block: three 8-pin ports, Avalon-MM register slave,
// synchronised inputs, wake detection and external regulator control.
// Assumes pads, peripherals and DEEP_SLEEP are synchronous to SYS_CLK.
`timescale 1ns/1ns

// Notes on behaviour
// - 24 pins, each configurable as output, alternate, analog or input.
// - Three ports of eight; pin index equals register bit position.
// - Each port's pins sit in the low eight bits of its registers.
// - Synchronised input feeds input register, peripherals and wake detection.
// - Analog mode cuts the digital input and feeds a high level.
// - Input register reads pin levels, analog pins excepted.
// - One output source per pin: output register or peripheral.
// - Input and analog modes switch the output driver off, except on pin 7 while the regulator override drives it low in deep sleep.
// - Writing clear register clears matching output bits.
// - Writing set register sets matching output bits.
// - Wake mask selects pins that may wake from deep sleep.
// - Low config register covers pins 3:0, high covers 7:4.
// - Both internal regulators are off in deep sleep.
// - Regulator-enable pin driven low in deep sleep, released awake.
// - Mode codes: 0 analog, 4/8 input, 1/5 output, 9/D alternate.
// - Pulled input: output bit one pulls up, zero pulls down.
// - Alternate mode without peripheral drives zero.
module gpio_port_control (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  input  wire logic [23:0] PAD_IN,
  output logic      [23:0] PAD_OUT,
  output logic      [23:0] PAD_OE_N,
  output logic      [23:0] PULL_EN,
  output logic      [23:0] PULL_UP,
  output logic      [23:0] ANALOG_EN,
  input  wire logic [23:0] ALT_OUT,
  input  wire logic [23:0] ALT_PRESENT,
  output logic      [23:0] PIN_LEVEL,
  input  wire logic        DEEP_SLEEP,
  output logic             WAKE_REQ,
  output logic             REG_1V8_EN,
  output logic             REG_1V25_EN
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0][15:0] cfgl;
    logic [2:0][15:0] cfgh;
    logic [2:0][7:0]  out;
    logic [2:0][7:0]  wake;
    logic [2:0]       ctrl;
    logic [23:0]      sync1;
    logic [23:0]      sync2;
    logic [23:0]      last;
    logic             wake_pulse;
    logic             sleep;
    logic             v18_en;
    logic             v125_en;
    logic             ack;
    logic [31:0]      rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [23:0] in_stage;
  logic [23:0] out_flat;
  logic [23:0] wake_flat;
  logic [1:0]  blk;
  logic [2:0]  reg_sel;
  logic        mapped;
  logic        req;
  logic [31:0] rd_mux;

  assign blk     = ADDRESS[6:5];
  assign reg_sel = ADDRESS[4:2];
  assign mapped  = ~ADDRESS[7];
  assign req     = READ | WRITE;

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < gpio_pkg::NPIN; gi = gi + 1) begin : g_pin
      localparam int P = gi / gpio_pkg::PINS;
      localparam int B = gi % gpio_pkg::PINS;
      logic [3:0] mode;
      // Low register holds pins 3:0, high register pins 7:4
      assign mode = (B < 4) ? s_q.cfgl[P][4*(B%4) +: 4]
                            : s_q.cfgh[P][4*(B%4) +: 4];
      gpio_pin_cell u_cell (
        .mode      (mode),
        .out_bit   (out_flat[gi]),
        .alt_bit   (ALT_OUT[gi]),
        .alt_ok    (ALT_PRESENT[gi]),
        .pad_in    (PAD_IN[gi]),
        .force_od  ((gi == gpio_pkg::REG_PIN) && s_q.ctrl[gpio_pkg::CTRL_EXTREG]),
        .force_low (s_q.sleep),
        .pad_out   (PAD_OUT[gi]),
        .pad_oe_n  (PAD_OE_N[gi]),
        .pull_en   (PULL_EN[gi]),
        .pull_up   (PULL_UP[gi]),
        .analog    (ANALOG_EN[gi]),
        .in_stage  (in_stage[gi])
      );
    end
  endgenerate

  assign out_flat  = s_q.out;
  assign wake_flat = s_q.wake;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (!mapped) begin
      rd_mux = 32'h0000_0000;
    end else if (blk == gpio_pkg::BLK_MISC) begin
      if (reg_sel == gpio_pkg::REG_CTRL) begin
        rd_mux = {29'h0000_0000, s_q.ctrl};
      end else if (reg_sel == gpio_pkg::REG_STAT) begin
        rd_mux = {28'h000_0000, s_q.v125_en, s_q.v18_en, s_q.wake_pulse, s_q.sleep};
      end
    end else if (reg_sel == gpio_pkg::REG_CFGL) begin
      rd_mux = {16'h0000, s_q.cfgl[blk]};
    end else if (reg_sel == gpio_pkg::REG_CFGH) begin
      rd_mux = {16'h0000, s_q.cfgh[blk]};
    end else if (reg_sel == gpio_pkg::REG_IN) begin
      // Analog pins already read high through the input stage
      rd_mux = {24'h00_0000, s_q.sync2[8*blk +: 8]};
    end else if (reg_sel == gpio_pkg::REG_OUT) begin
      rd_mux = {24'h00_0000, s_q.out[blk]};
    end else if (reg_sel == gpio_pkg::REG_WAKE) begin
      rd_mux = {24'h00_0000, s_q.wake[blk]};
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Two stages before anything looks at a pad level
    s_d.sync1 = in_stage;
    s_d.sync2 = s_q.sync1;
    s_d.last  = s_q.sync2;

    // Any masked pin changing level raises a wake request
    s_d.wake_pulse = |((s_q.sync2 ^ s_q.last) & wake_flat);

    // Sleep and regulator enables are registered to keep outputs glitch free
    s_d.sleep   = DEEP_SLEEP;
    s_d.v18_en  = s_q.ctrl[gpio_pkg::CTRL_V18] & ~DEEP_SLEEP;
    s_d.v125_en = s_q.ctrl[gpio_pkg::CTRL_V125] & ~DEEP_SLEEP;

    // One wait state: data is captured in the first cycle of a request
    s_d.ack = req & ~s_q.ack;
    if (req && !s_q.ack) begin
      s_d.rdata = READ ? rd_mux : 32'h0000_0000;
    end

    // Writes take effect on the edge where waitrequest is low
    if (WRITE && s_q.ack && mapped) begin
      if (blk == gpio_pkg::BLK_MISC) begin
        if (reg_sel == gpio_pkg::REG_CTRL && BYTEENABLE[0]) begin
          s_d.ctrl = WRITEDATA[2:0];
        end
      end else if (reg_sel == gpio_pkg::REG_CFGL) begin
        s_d.cfgl[blk] = gpio_pkg::merge16(s_q.cfgl[blk], WRITEDATA, BYTEENABLE);
      end else if (reg_sel == gpio_pkg::REG_CFGH) begin
        s_d.cfgh[blk] = gpio_pkg::merge16(s_q.cfgh[blk], WRITEDATA, BYTEENABLE);
      end else if (reg_sel == gpio_pkg::REG_OUT) begin
        s_d.out[blk] = gpio_pkg::merge8(s_q.out[blk], WRITEDATA, BYTEENABLE);
      end else if (reg_sel == gpio_pkg::REG_SET) begin
        if (BYTEENABLE[0]) begin
          s_d.out[blk] = s_q.out[blk] | WRITEDATA[7:0];
        end
      end else if (reg_sel == gpio_pkg::REG_CLR) begin
        if (BYTEENABLE[0]) begin
          s_d.out[blk] = s_q.out[blk] & ~WRITEDATA[7:0];
        end
      end else if (reg_sel == gpio_pkg::REG_WAKE) begin
        s_d.wake[blk] = gpio_pkg::merge8(s_q.wake[blk], WRITEDATA, BYTEENABLE);
      end
    end

    if (!RESETN) begin
      s_d.cfgl       = {3{gpio_pkg::CFG_RST}};
      s_d.cfgh       = {3{gpio_pkg::CFG_RST}};
      s_d.out        = {3{gpio_pkg::OUT_RST}};
      s_d.wake       = {3{gpio_pkg::WAKE_RST}};
      s_d.ctrl       = gpio_pkg::CTRL_RST;
      s_d.sync1      = 24'hFF_FFFF;
      s_d.sync2      = 24'hFF_FFFF;
      s_d.last       = 24'hFF_FFFF;
      s_d.wake_pulse = 1'b0;
      s_d.sleep      = 1'b0;
      s_d.v18_en     = 1'b0;
      s_d.v125_en    = 1'b0;
      s_d.ack        = 1'b0;
      s_d.rdata      = 32'h0000_0000;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign WAITREQUEST = req & ~s_q.ack;
  assign READDATA    = s_q.rdata;
  assign PIN_LEVEL   = s_q.sync2;
  assign WAKE_REQ    = s_q.wake_pulse;
  assign REG_1V8_EN  = s_q.v18_en;
  assign REG_1V25_EN = s_q.v125_en;

endmodule : gpio_port_control

// file: verif/gpio_port_control_asserts.sv
// Checker for the GPIO port block, bound to its top module.
// Assumes the external-regulator override stays on for the whole run.
`timescale 1ns/1ns
module gpio_port_control_asserts (
  input wire logic        SYS_CLK,
  input wire logic        RESETN,
  input wire logic [7:0]  ADDRESS,
  input wire logic        READ,
  input wire logic        WRITE,
  input wire logic [31:0] READDATA,
  input wire logic        WAITREQUEST,
  input wire logic [23:0] PAD_IN,
  input wire logic [23:0] PAD_OE_N,
  input wire logic [23:0] PULL_EN,
  input wire logic [23:0] ANALOG_EN,
  input wire logic [23:0] PIN_LEVEL,
  input wire logic        DEEP_SLEEP,
  input wire logic        WAKE_REQ,
  input wire logic        REG_1V8_EN,
  input wire logic        REG_1V25_EN
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  a_wait_start: assert property ((READ || WRITE) && !$past(READ || WRITE) |-> WAITREQUEST)
    else $error("no wait state on new request");
  a_wait_once: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("wait state longer than one cycle");
  a_upper_zero: assert property (READ && !WAITREQUEST && ADDRESS[6:5] != 2'h3
    && ADDRESS[4:2] > 3'h1 |-> READDATA[31:8] == 24'h0)
    else $error("upper bits of 8-bit register not zero");
  a_unmapped_zero: assert property (READ && !WAITREQUEST && ADDRESS[7] |-> READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_driver_off: assert property (((ANALOG_EN | PULL_EN) & ~PAD_OE_N & 24'hFFFF7F) == 24'h0)
    else $error("driver on in input or analog mode");
  a_sync_level: assert property ($past(RESETN) && $past(RESETN, 2)
    |-> PIN_LEVEL == ($past(PAD_IN, 2) | $past(ANALOG_EN, 2)))
    else $error("pin level not two cycles behind pad");
  a_regs_sleep: assert property ({REG_1V8_EN, REG_1V25_EN} != 2'h0 |-> !$past(DEEP_SLEEP))
    else $error("regulator on in deep sleep");
  a_ext_reg: assert property ($past(RESETN) |-> PAD_OE_N[7] == !$past(DEEP_SLEEP))
    else $error("regulator pin not following sleep");
  a_wake_change: assert property (WAKE_REQ |-> $past(PIN_LEVEL) != $past(PIN_LEVEL, 2))
    else $error("wake without pin change");
endmodule : gpio_port_control_asserts

bind gpio_port_control gpio_port_control_asserts u_gpio_port_control_asserts (.*);

// file: verif/gpio_pad_model.sv
// Board side of the pins: block drive wins, then pin 7 reads high, then pulls, then outside level.
// Assumes open-drain pins only enable their driver to pull low.
`timescale 1ns/1ns
module gpio_pad_model (
  input  wire logic [23:0] pad_out,
  input  wire logic [23:0] pad_oe_n,
  input  wire logic [23:0] pull_en,
  input  wire logic [23:0] pull_up,
  input  wire logic [23:0] ext_level,
  output logic      [23:0] pad_level
);
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (!pad_oe_n[i]) pad_level[i] = pad_out[i];
      else if (i == 7) pad_level[i] = 1'b1;
      else if (pull_en[i]) pad_level[i] = pull_up[i];
      else pad_level[i] = ext_level[i];
    end
  end
endmodule : gpio_pad_model

// file: verif/gpio_port_control_tb.sv
// Self-checking bench for the GPIO port block and its pad model.
// Assumes pads settle within a cycle; pin outputs are sampled 1 ns past the edge.
`timescale 1ns/1ns
module gpio_port_control_tb;
  logic        SYS_CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic [7:0]  ADDRESS = 8'h00;
  logic        READ = 1'b0;
  logic        WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0;
  logic [3:0]  BYTEENABLE = 4'hF;
  logic [23:0] ALT_OUT = 24'h0;
  logic [23:0] ALT_PRESENT = 24'h0;
  logic [23:0] ext_level = 24'h0;
  logic        DEEP_SLEEP = 1'b0;
  logic [31:0] READDATA;
  logic        WAITREQUEST;
  logic [23:0] PAD_IN, PAD_OUT, PAD_OE_N, PULL_EN, PULL_UP, ANALOG_EN, PIN_LEVEL;
  logic        WAKE_REQ, REG_1V8_EN, REG_1V25_EN;
  int          fails = 0;
  int          num_checks = 0;

  always #10 SYS_CLK = ~SYS_CLK;
  gpio_port_control u_gpio_port_control (.*);
  gpio_pad_model u_gpio_pad_model (.pad_out(PAD_OUT), .pad_oe_n(PAD_OE_N),
    .pull_en(PULL_EN), .pull_up(PULL_UP), .ext_level(ext_level), .pad_level(PAD_IN));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Request held until the edge that sees WAITREQUEST low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge SYS_CLK);
    ADDRESS <= a;
    WRITEDATA <= d;
    WRITE <= wr;
    READ <= !wr;
    @(posedge SYS_CLK);
    // Read before this edge's updates land; only the watchdog ends a hang
    while (WAITREQUEST !== 1'b0) @(posedge SYS_CLK);
    q = READDATA;
    WRITE <= 1'b0;
    READ <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd_chk

  task automatic settle();
    repeat (3) @(posedge SYS_CLK);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int p = 0; p < 3; p++) begin
      rd_chk(8'(p * 32), 32'h4444);
      rd_chk(8'(p * 32 + 24), 32'h0);
      wr(8'(p * 32 + 12), 32'hFFFFFF00 | 32'((p + 1) * 17));
    end
    for (int p = 0; p < 3; p++) rd_chk(8'(p * 32 + 12), 32'((p + 1) * 17));
  endtask : t_reset

  task automatic t_setclr();
    wr(8'h2C, 32'hA5);
    wr(8'h30, 32'h0A);
    rd_chk(8'h2C, 32'hAF);
    wr(8'h34, 32'h81);
    rd_chk(8'h2C, 32'h2E);
    rd_chk(8'h30, 32'h0);
  endtask : t_setclr

  task automatic t_modes();
    @(posedge SYS_CLK);
    ALT_OUT <= 24'h000400;
    ALT_PRESENT <= 24'h008400;
    ext_level <= 24'h002000;
    wr(8'h20, 32'h9951);
    wr(8'h24, 32'hD840);
    wr(8'h2C, 32'h43);
    settle();
    check(PAD_OE_N[15:8], 8'h72);
    check(PAD_OUT[15:8] & 8'h8D, 8'h05);
    check(ANALOG_EN[15:8], 8'h10);
    check(PULL_EN[15:8], 8'h40);
    check(PULL_UP[14], 1'b1);
    wr(8'h34, 32'h42);
    settle();
    check(PAD_OE_N[15:8], 8'h70);
    check(PULL_UP[14], 1'b0);
    check(PIN_LEVEL[15:8], 8'h35);
    rd_chk(8'h28, 32'h35);
  endtask : t_modes

  task automatic t_wake(input int bit_no, input int exp);
    int hit;
    hit = 0;
    @(posedge SYS_CLK);
    ext_level[bit_no] <= 1'b1;
    repeat (8) begin
      @(posedge SYS_CLK);
      #1;
      if (WAKE_REQ === 1'b1) hit++;
    end
    check(hit, exp);
  endtask : t_wake

  task automatic t_sleep();
    @(posedge SYS_CLK);
    DEEP_SLEEP <= 1'b1;
    settle();
    check({REG_1V8_EN, REG_1V25_EN}, 2'h0);
    check({PAD_OE_N[7], PAD_IN[7]}, 2'h0);
    rd_chk(8'h64, 32'h1);
    @(posedge SYS_CLK);
    DEEP_SLEEP <= 1'b0;
    settle();
    check({PAD_OE_N[7], PAD_IN[7]}, 2'h3);
    check({REG_1V8_EN, REG_1V25_EN}, 2'h3);
    wr(8'h60, 32'h1);
    settle();
    check({REG_1V8_EN, REG_1V25_EN}, 2'h0);
    rd_chk(8'h60, 32'h1);
  endtask : t_sleep

  task automatic t_unmapped();
    wr(8'h80, 32'hFF);
    rd_chk(8'h80, 32'h0);
    wr(8'h08, 32'hFF);
    rd_chk(8'h08, 32'h80);
    rd_chk(8'h9C, 32'h0);
  endtask : t_unmapped

  initial begin
    #200000;
    fails++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    t_reset();
    t_setclr();
    t_modes();
    wr(8'h58, 32'h01);
    t_wake(16, 1);
    t_wake(17, 0);
    t_sleep();
    t_unmapped();
    complete_run();
  end
endmodule : gpio_port_control_tb
